// File: design/pin_edge_sync.sv
`timescale 1ns/1ps
module pin_edge_sync (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic pin_in,
	output logic level_out,
	output logic rise_out,
	output logic fall_out
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic agree;
	logic change;

	// A change counts only once the second and third stages agree
	assign agree = (s2_reg == s3_reg);
	assign change = agree & (s3_reg != level_out);

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			level_out <= 1'b0;
			rise_out <= 1'b0;
			fall_out <= 1'b0;
		end else begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (agree) begin
				level_out <= s3_reg;
			end
			rise_out <= change & s3_reg;
			fall_out <= change & ~s3_reg;
		end
	end
endmodule

// File: design/timer_control.sv
`timescale 1ns/1ps
// What this block does
// - The timer advances only while the run enable bit 7 is set.
// - Run enable, prescale and low mode bits are read/write and reset to 0.
// - In count-style modes the output idles at polarity and toggles on reload.
// - Counter mode counts rising edges at polarity 0, falling at 1.
// - PWM at polarity 0 idles low, goes high on match and low on reload.
// - PWM at polarity 1 idles high, goes low on match and high on reload.
// - Capture mode at polarity 0 captures the count on rising input edges.
// - Gated at polarity 0 counts while input high, interrupts on its fall.
// - Gated at polarity 1 counts while input low, interrupts on its rise.
// - Capture/compare at polarity 0 starts on a rise, captures on later ones.
// - Capture/compare at polarity 1 starts on a fall, captures on later ones.
// - Captured counts land in the 16-bit compare/capture value register.
// - Mode is four bits: top bit in control 0, low three in control 1.
module timer_control
	import timer_ctl_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input wire logic CLK_IN,
	input wire logic ARST_N_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [15:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	input wire logic TIMER_IN,
	output logic TIMER_OUT,
	output logic IRQ_OUT
);

	function automatic logic [7:0] presc_limit(input logic [2:0] sel);
		presc_limit = 8'((9'h001 << sel) - 9'h001);
	endfunction

	// Register state
	logic [7:0] timer_control_one_reg;
	logic [7:0] timer_control_one_next;
	logic mode_hi_reg;
	logic [CNT_W-1:0] compare_capture_value_reg;
	logic [CNT_W-1:0] compare_capture_value_next;
	logic [CNT_W-1:0] reload_value_reg;
	logic [CNT_W-1:0] count_reg;
	logic [CNT_W-1:0] count_next;
	logic [7:0] presc_reg;
	logic [7:0] presc_next;
	logic out_reg;
	logic out_next;
	logic [ST_W-1:0] status_reg;
	logic [ST_W-1:0] status_next;
	logic [ST_W-1:0] mask_reg;
	logic irq_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	cc_state_type cc_state_reg;
	cc_state_type cc_state_next;

	// Input pin conditioning
	logic in_level;
	logic in_rise;
	logic in_fall;

	pin_edge_sync u_sync (
		.clk_in(CLK_IN),
		.arst_n_in(ARST_N_IN),
		.pin_in(TIMER_IN),
		.level_out(in_level),
		.rise_out(in_rise),
		.fall_out(in_fall)
	);

	// Control fields
	logic run_enable_bit;
	logic io_polarity_bit;
	logic [2:0] prescale_select;
	logic [3:0] operating_mode_select;

	assign run_enable_bit = timer_control_one_reg[RUN_BIT];
	assign io_polarity_bit = timer_control_one_reg[POL_BIT];
	assign prescale_select = timer_control_one_reg[PRESCALE_SELECT_MSB:PRESCALE_SELECT_LSB];
	assign operating_mode_select = {mode_hi_reg,
		timer_control_one_reg[MODE_MSB:MODE_LSB]};

	// Mode decode
	logic is_oneshot;
	logic is_counter;
	logic is_pwm;
	logic is_capture;
	logic is_compare;
	logic is_gated;
	logic is_capcmp;

	assign is_oneshot = (operating_mode_select == MODE_ONESHOT);
	assign is_counter = (operating_mode_select == MODE_COUNTER);
	assign is_pwm = (operating_mode_select == MODE_PWM);
	assign is_capture = (operating_mode_select == MODE_CAPTURE);
	assign is_compare = (operating_mode_select == MODE_COMPARE);
	assign is_gated = (operating_mode_select == MODE_GATED);
	assign is_capcmp = (operating_mode_select == MODE_CAPCMP);

	// Edge selection by polarity
	logic act_edge;
	logic deassert_edge;
	logic gate_open;

	assign act_edge = io_polarity_bit ? in_fall : in_rise;
	assign deassert_edge = io_polarity_bit ? in_rise : in_fall;
	assign gate_open = in_level ^ io_polarity_bit;

	// Count tick
	logic presc_tick;
	logic count_tick;
	logic [CNT_W-1:0] term_value;
	logic at_term;

	assign presc_tick = run_enable_bit &
		(presc_reg == presc_limit(prescale_select));
	assign count_tick = !run_enable_bit ? 1'b0 :
		is_counter ? act_edge :
		is_gated ? (presc_tick & gate_open) :
		is_capcmp ? (presc_tick & (cc_state_reg == CC_RUN)) :
		presc_tick;
	// Compare mode ends its period at the compare value
	assign term_value = is_compare ? compare_capture_value_reg :
		reload_value_reg;
	assign at_term = (count_reg == term_value);

	// Events
	logic reload_ev;
	logic match_ev;
	logic capture_ev;
	logic gate_ev;
	logic [ST_W-1:0] events;

	assign reload_ev = count_tick & at_term;
	assign match_ev = count_tick & is_pwm &
		(count_reg == compare_capture_value_reg);
	assign capture_ev = run_enable_bit & act_edge & (is_capture |
		(is_capcmp & (cc_state_reg == CC_RUN)));
	assign gate_ev = run_enable_bit & is_gated & deassert_edge;

	always_comb begin
		events = '0;
		events[ST_RELOAD] = reload_ev;
		events[ST_MATCH] = match_ev;
		events[ST_CAPTURE] = capture_ev;
		events[ST_GATE] = gate_ev;
	end

	// Bus decode
	logic bus_access;
	logic bus_write;
	logic bus_read;
	logic [13:0] word_index;
	logic aligned;
	logic hit_cmp;
	logic hit_ctl0;
	logic hit_ctl1;
	logic hit_rld;
	logic hit_cnt;
	logic hit_stat;
	logic hit_mask;
	logic hit_any;

	// One wait state: the answer comes on the second access cycle
	assign bus_access = PSEL_IN & PENABLE_IN & ~pready_reg;
	assign bus_write = bus_access & PWRITE_IN;
	assign bus_read = bus_access & ~PWRITE_IN;
	assign word_index = PADDR_IN[15:2];
	assign aligned = (PADDR_IN[1:0] == 2'b00);
	assign hit_cmp = aligned & (word_index == IDX_CMP);
	assign hit_ctl0 = aligned & (word_index == IDX_CTL0);
	assign hit_ctl1 = aligned & (word_index == IDX_CTL1);
	assign hit_rld = aligned & (word_index == IDX_RLD);
	assign hit_cnt = aligned & (word_index == IDX_CNT);
	assign hit_stat = aligned & (word_index == IDX_STAT);
	assign hit_mask = aligned & (word_index == IDX_MASK);
	assign hit_any = hit_cmp | hit_ctl0 | hit_ctl1 | hit_rld |
		hit_cnt | hit_stat | hit_mask;

	logic [31:0] read_mux;

	assign read_mux =
		hit_cmp ? {{(32-CNT_W){1'b0}}, compare_capture_value_reg} :
		hit_ctl0 ? {24'h000000, mode_hi_reg, 7'h00} :
		hit_ctl1 ? {24'h000000, timer_control_one_reg} :
		hit_rld ? {{(32-CNT_W){1'b0}}, reload_value_reg} :
		hit_cnt ? {{(32-CNT_W){1'b0}}, count_reg} :
		hit_stat ? {{(32-ST_W){1'b0}}, status_reg} :
		hit_mask ? {{(32-ST_W){1'b0}}, mask_reg} :
		32'h00000000;

	// Control 1: software write, one-shot self-clear of run enable
	always_comb begin
		timer_control_one_next = timer_control_one_reg;
		if (bus_write & hit_ctl1) begin
			timer_control_one_next = PWDATA_IN[7:0];
		end else if (is_oneshot & reload_ev) begin
			timer_control_one_next[RUN_BIT] = 1'b0;
		end
	end

	// Capture beats a software write in the same cycle
	assign compare_capture_value_next =
		capture_ev ? count_reg :
		(bus_write & hit_cmp) ? PWDATA_IN[CNT_W-1:0] :
		compare_capture_value_reg;

	// Counter and prescaler
	always_comb begin
		count_next = count_reg;
		if (bus_write & hit_cnt) begin
			count_next = PWDATA_IN[CNT_W-1:0];
		end else if (reload_ev) begin
			count_next = CNT_START;
		end else if (count_tick) begin
			count_next = count_reg + 1'b1;
		end
	end

	assign presc_next = (!run_enable_bit || presc_tick) ? 8'h00 :
		presc_reg + 8'h01;

	// Capture/compare start tracking
	always_comb begin
		cc_state_next = cc_state_reg;
		unique case (cc_state_reg)
			CC_WAIT: begin
				if (run_enable_bit & is_capcmp & act_edge) begin
					cc_state_next = CC_RUN;
				end
			end
			CC_RUN: begin
				if (!run_enable_bit | !is_capcmp) begin
					cc_state_next = CC_WAIT;
				end
			end
		endcase
	end

	// Timer output
	always_comb begin
		out_next = out_reg;
		if (!run_enable_bit) begin
			out_next = io_polarity_bit;
		end else if (is_pwm) begin
			if (reload_ev) begin
				out_next = io_polarity_bit;
			end else if (match_ev) begin
				out_next = ~io_polarity_bit;
			end
		end else if (reload_ev) begin
			out_next = ~out_reg;
		end
	end

	// Sticky status; a new event wins over the read that clears it
	assign status_next = (status_reg &
		~((bus_read & hit_stat) ? status_reg : '0)) | events;

	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			timer_control_one_reg <= CTL_RST;
			mode_hi_reg <= 1'b0;
			compare_capture_value_reg <= CMP_RST;
			reload_value_reg <= RLD_RST;
		end else begin
			timer_control_one_reg <= timer_control_one_next;
			compare_capture_value_reg <= compare_capture_value_next;
			if (bus_write & hit_ctl0) begin
				mode_hi_reg <= PWDATA_IN[MODE_HI_BIT];
			end
			if (bus_write & hit_rld) begin
				reload_value_reg <= PWDATA_IN[CNT_W-1:0];
			end
		end
	end

	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			count_reg <= CNT_RST;
			presc_reg <= 8'h00;
			cc_state_reg <= CC_WAIT;
			out_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			presc_reg <= presc_next;
			cc_state_reg <= cc_state_next;
			out_reg <= out_next;
		end
	end

	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			status_reg <= '0;
			mask_reg <= '0;
			irq_reg <= 1'b0;
		end else begin
			status_reg <= status_next;
			if (bus_write & hit_mask) begin
				mask_reg <= PWDATA_IN[ST_W-1:0];
			end
			irq_reg <= |(status_next & mask_reg);
		end
	end

	// Unmapped or misaligned access answers with an error, reads zero
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			prdata_reg <= 32'h00000000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= bus_access;
			pslverr_reg <= bus_access & ~hit_any;
			if (bus_read) begin
				prdata_reg <= read_mux;
			end
		end
	end

	assign PRDATA_OUT = prdata_reg;
	assign PREADY_OUT = pready_reg;
	assign PSLVERR_OUT = pslverr_reg;
	assign TIMER_OUT = out_reg;
	assign IRQ_OUT = irq_reg;

endmodule

// File: inc/timer_ctl_pkg.sv
package timer_ctl_pkg;

	// Register indices; byte address is four times the index
	localparam logic [13:0] IDX_CMP = 14'h0f04;
	localparam logic [13:0] IDX_CTL0 = 14'h0f06;
	localparam logic [13:0] IDX_CTL1 = 14'h0f07;
	localparam logic [13:0] IDX_RLD = 14'h0f08;
	localparam logic [13:0] IDX_CNT = 14'h0f09;
	localparam logic [13:0] IDX_STAT = 14'h0f0a;
	localparam logic [13:0] IDX_MASK = 14'h0f0b;

	// Control 1 fields
	localparam int RUN_BIT = 7;
	localparam int POL_BIT = 6;
	localparam int PRESCALE_SELECT_MSB = 5;
	localparam int PRESCALE_SELECT_LSB = 3;
	localparam int MODE_MSB = 2;
	localparam int MODE_LSB = 0;
	// Control 0 field
	localparam int MODE_HI_BIT = 7;

	// Reset values
	localparam logic [7:0] CTL_RST = 8'h00;
	localparam logic [15:0] CMP_RST = 16'h0000;
	localparam logic [15:0] RLD_RST = 16'hffff;
	localparam logic [15:0] CNT_RST = 16'h0001;
	localparam logic [15:0] CNT_START = 16'h0001;

	// Operating mode codes
	localparam logic [3:0] MODE_ONESHOT = 4'h0;
	localparam logic [3:0] MODE_CONT = 4'h1;
	localparam logic [3:0] MODE_COUNTER = 4'h2;
	localparam logic [3:0] MODE_PWM = 4'h3;
	localparam logic [3:0] MODE_CAPTURE = 4'h4;
	localparam logic [3:0] MODE_COMPARE = 4'h5;
	localparam logic [3:0] MODE_GATED = 4'h6;
	localparam logic [3:0] MODE_CAPCMP = 4'h7;

	// Interrupt status bit positions
	localparam int ST_W = 4;
	localparam int ST_RELOAD = 0;
	localparam int ST_MATCH = 1;
	localparam int ST_CAPTURE = 2;
	localparam int ST_GATE = 3;

	typedef enum logic {CC_WAIT, CC_RUN} cc_state_type;

endpackage

// File: verif/timer_control_sva.sv
`timescale 1ns/1ps
module timer_control_sva
	import timer_ctl_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input wire logic CLK_IN,
	input wire logic ARST_N_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [15:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	input wire logic [31:0] PRDATA_OUT,
	input wire logic PREADY_OUT,
	input wire logic PSLVERR_OUT,
	input wire logic TIMER_IN,
	input wire logic TIMER_OUT,
	input wire logic IRQ_OUT
);
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!ARST_N_IN);
	logic [7:0] ctl_reg;
	logic hi_reg;
	logic [3:0] mask_reg;
	wire [13:0] idx = PADDR_IN[15:2];
	wire ok = PADDR_IN[1:0] == 2'b00;
	wire done = PSEL_IN && PENABLE_IN && PREADY_OUT;
	wire wr = done && PWRITE_IN && ok;
	wire rd = done && !PWRITE_IN;
	wire mapped = ok && (idx == IDX_CMP || idx == IDX_CTL0 ||
		idx == IDX_CTL1 || idx == IDX_RLD || idx == IDX_CNT ||
		idx == IDX_STAT || idx == IDX_MASK);
	// Shadow of software writes; one-shot self-clear is not tracked
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			ctl_reg <= CTL_RST;
			hi_reg <= 1'b0;
			mask_reg <= 4'h0;
		end else if (wr) begin
			if (idx == IDX_CTL1) ctl_reg <= PWDATA_IN[7:0];
			if (idx == IDX_CTL0) hi_reg <= PWDATA_IN[MODE_HI_BIT];
			if (idx == IDX_MASK) mask_reg <= PWDATA_IN[3:0];
		end
	end
	sequence taken_s;
		PSEL_IN && PENABLE_IN && !PREADY_OUT;
	endsequence
	sequence pulse_s;
		PREADY_OUT ##1 !PREADY_OUT;
	endsequence
	apb_answer_a: assert property (taken_s |=> pulse_s)
		else $error("ready not one cycle after access");
	ready_cause_a: assert property (PREADY_OUT |-> $past(PSEL_IN && PENABLE_IN))
		else $error("ready without access");
	slverr_map_a: assert property (done |-> PSLVERR_OUT == !mapped)
		else $error("error flag wrong for address");
	refused_zero_a: assert property (rd && PSLVERR_OUT |-> PRDATA_OUT == 32'h0)
		else $error("refused read not zero");
	upper_zero_a: assert property (rd |-> PRDATA_OUT[31:16] == 16'h0)
		else $error("upper read bits set");
	// Mode 0 excluded: it may clear the run bit itself
	ctl_read_a: assert property (rd && ok && idx == IDX_CTL1 &&
		(hi_reg || ctl_reg[2:0] != 3'h0) |-> PRDATA_OUT[7:0] == ctl_reg)
		else $error("control read mismatch");
	mode_hi_a: assert property (rd && ok && idx == IDX_CTL0 |->
		PRDATA_OUT[MODE_HI_BIT] == hi_reg)
		else $error("mode top bit mismatch");
	idle_level_a: assert property (!ctl_reg[RUN_BIT] && $stable(ctl_reg) |->
		TIMER_OUT == ctl_reg[POL_BIT])
		else $error("idle output not polarity");
	irq_masked_a: assert property (mask_reg == 4'h0 &&
		$past(mask_reg) == 4'h0 |-> !IRQ_OUT)
		else $error("interrupt while masked");
endmodule
bind timer_control timer_control_sva #(.CNT_W(CNT_W)) i_sva (.*);

// File: verif/timer_control_tb.sv
`timescale 1ns/1ps
module timer_control_tb;
	import timer_ctl_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, rd, pol;
	logic pready, pslverr, tin, tout, irq, err;
	logic [15:0] edges, e0;
	int num_errors = 0;
	int cmp_count = 0;
	int n;
	logic [13:0] ri [6] = '{IDX_CTL1, IDX_CMP, IDX_RLD, IDX_CNT, IDX_STAT,
		IDX_MASK};
	logic [15:0] rv [6] = '{16'(CTL_RST), CMP_RST, RLD_RST, CNT_RST,
		16'h0000, 16'h0000};
	initial forever #12.5 clk = ~clk;
	timer_control #(.CNT_W(16)) i_dut (.CLK_IN(clk), .ARST_N_IN(rst_n),
		.PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
		.PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
		.PSLVERR_OUT(pslverr), .TIMER_IN(tin), .TIMER_OUT(tout),
		.IRQ_OUT(irq));
	timer_pin_model i_pin (.clk_in(clk), .level_in(tout), .pin_out(tin),
		.edges_out(edges));
	task close_out;
		$display("errors %0d checks %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task check_w(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task check_b(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [13:0] i, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= {i, 2'b00};
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task wr(input logic [13:0] i, input logic [31:0] d);
		apb(1'b1, i, d);
	endtask
	// Polarity set while stopped, so no false edge at start
	task setup(input logic [31:0] ctl);
		wr(IDX_CTL1, ctl & 32'h7f);
		wr(IDX_CNT, 32'h1);
		wr(IDX_CTL1, ctl);
		repeat (20) @(posedge clk);
		apb(1'b0, IDX_CNT, 32'h0);
	endtask
	task edge_pair(input logic [31:0] m, input logic [31:0] first);
		apb(1'b0, IDX_STAT, 32'h0);
		i_pin.flip(6);
		apb(1'b0, IDX_STAT, 32'h0);
		check_w(rd & m, first);
		i_pin.flip(6);
		apb(1'b0, IDX_STAT, 32'h0);
		check_w(rd & m, first ^ m);
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		close_out;
	end
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		for (int k = 0; k < 6; k++) begin
			apb(1'b0, ri[k], 32'h0);
			check_w(rd, {16'h0000, rv[k]});
		end
		apb(1'b0, 14'h0f05, 32'h0);
		check_b(err, 1'b1);
		wr(IDX_CTL0, 32'h80);
		wr(IDX_CTL1, 32'h3f);
		apb(1'b0, IDX_CTL0, 32'h0);
		check_w(rd, 32'h80);
		apb(1'b0, IDX_CTL1, 32'h0);
		check_w(rd, 32'h3f);
		wr(IDX_CTL0, 32'h0);
		wr(IDX_RLD, 32'h3);
		setup(32'h01);
		check_w(rd, 32'h1);
		e0 = edges;
		setup(32'h81);
		check_b(irq, 1'b0);
		wr(IDX_MASK, 32'hf);
		repeat (2) @(posedge clk);
		check_b(irq, 1'b1);
		check_b(edges - e0 > 16'd8, 1'b1);
		wr(IDX_CTL1, 32'h41);
		repeat (2) @(posedge clk);
		check_b(tout, 1'b1);
		apb(1'b0, IDX_STAT, 32'h0);
		check_w(rd, 32'h1);
		repeat (2) @(posedge clk);
		check_b(irq, 1'b0);
		wr(IDX_RLD, 32'hffff);
		for (int p = 0; p < 2; p++) begin
			pol = 32'(p) << 6;
			setup(32'h82 | pol);
			repeat (5) i_pin.flip(6);
			apb(1'b0, IDX_CNT, 32'h0);
			check_w(rd, 32'h4);
		end
		for (int p = 0; p < 2; p++) begin
			pol = 32'(p) << 6;
			setup(32'h84 | pol);
			edge_pair(32'h4, p ? 32'h0 : 32'h4);
		end
		apb(1'b0, IDX_CMP, 32'h0);
		check_b(rd[15:0] > 16'h0001, 1'b1);
		for (int p = 0; p < 2; p++) begin
			pol = 32'(p) << 6;
			setup(32'h86 | pol);
			check_b(rd === 32'h1, p == 0);
			edge_pair(32'h8, p ? 32'h8 : 32'h0);
		end
		for (int p = 0; p < 2; p++) begin
			pol = 32'(p) << 6;
			setup(32'h87 | pol);
			check_w(rd, 32'h1);
			repeat (2) i_pin.flip(6);
			edge_pair(32'h4, p ? 32'h0 : 32'h4);
		end
		// Match one count before reload, so duty tells match from reload
		wr(IDX_CMP, 32'h3);
		wr(IDX_RLD, 32'h4);
		for (int p = 0; p < 2; p++) begin
			pol = 32'(p) << 6;
			setup(32'h83 | pol);
			apb(1'b0, IDX_STAT, 32'h0);
			check_w(rd & 32'h3, 32'h3);
			n = 0;
			repeat (8) begin
				@(posedge clk);
				if (tout !== pol[POL_BIT]) begin
					n++;
				end
			end
			check_w(32'(n), 32'h2);
			wr(IDX_CTL1, 32'h03 | pol);
			repeat (2) @(posedge clk);
			check_b(tout, pol[POL_BIT]);
		end
		// Compare mode ends its period at the compare value, not reload
		setup(32'h85);
		e0 = edges;
		repeat (12) @(posedge clk);
		check_w({16'h0000, edges - e0}, 32'h4);
		setup(32'h80);
		check_w(rd, 32'h1);
		apb(1'b0, IDX_CTL1, 32'h0);
		check_w(rd, 32'h0);
		close_out;
	end
endmodule

// File: verif/timer_pin_model.sv
`timescale 1ns/1ps
module timer_pin_model (
	input wire logic clk_in,
	input wire logic level_in,
	output logic pin_out,
	output logic [15:0] edges_out
);
	logic last_level = 1'b0;
	initial pin_out = 1'b0;
	initial edges_out = 16'h0000;
	always @(posedge clk_in) begin
		last_level <= level_in;
		if (level_in !== last_level) edges_out <= edges_out + 16'h0001;
	end
	// Held both sides so the three-stage synchroniser settles
	task flip(input int gap);
		repeat (gap) @(posedge clk_in);
		pin_out <= ~pin_out;
		repeat (gap) @(posedge clk_in);
	endtask
endmodule
